// ==== src/adcc_params.svh ====
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ==================================================================
// register byte offsets
`define ADCC_OFF_CLKEN    8'h00
`define ADCC_OFF_MODE0    8'h04
`define ADCC_OFF_MODE1    8'h08
`define ADCC_OFF_MODE2    8'h0c
`define ADCC_OFF_UPPER    8'h10
`define ADCC_OFF_LOWER    8'h14
`define ADCC_OFF_CHSEL    8'h18
`define ADCC_OFF_RESULT   8'h1c
`define ADCC_OFF_STATUS   8'h20
`define ADCC_OFF_MASK     8'h24

// ==================================================================
// reset values
`define ADCC_RST_CLKEN    8'h00
`define ADCC_RST_MODE0    8'h00
`define ADCC_RST_MODE1    8'h00
`define ADCC_RST_MODE2    8'h00
`define ADCC_RST_UPPER    8'hff
`define ADCC_RST_LOWER    8'h00
`define ADCC_RST_CHSEL    8'h00

// ==================================================================
// writable bits; the others read as zero
`define ADCC_WMASK_CLKEN  8'hff
`define ADCC_WMASK_MODE1  8'he3
`define ADCC_WMASK_MODE2  8'he5
`define ADCC_WMASK_CHSEL  8'h9f

// ==================================================================
// field positions
`define ADCC_CLKGATE_BIT  5
`define ADCC_START_BIT    7
`define ADCC_SCAN_BIT     6
`define ADCC_DIV_HI       5
`define ADCC_DIV_LO       3
`define ADCC_SPD_HI       2
`define ADCC_SPD_LO       1
`define ADCC_CMPEN_BIT    0
`define ADCC_TRG_HI       7
`define ADCC_TRG_LO       6
`define ADCC_ONESHOT_BIT  5
`define ADCC_TSRC_HI      1
`define ADCC_TSRC_LO      0
`define ADCC_PREF_HI      7
`define ADCC_PREF_LO      6
`define ADCC_NREF_BIT     5
`define ADCC_RCHK_BIT     3
`define ADCC_WAKE_BIT     2
`define ADCC_RES_BIT      0
`define ADCC_ISS_BIT      7
`define ADCC_CODE_HI      4
`define ADCC_CODE_LO      0

// ==================================================================
// conversion clock dividers, stored as ratio minus one
`define ADCC_DIVM1_64     6'h3f
`define ADCC_DIVM1_32     6'h1f
`define ADCC_DIVM1_16     6'h0f
`define ADCC_DIVM1_8      6'h07
`define ADCC_DIVM1_6      6'h05
`define ADCC_DIVM1_5      6'h04
`define ADCC_DIVM1_4      6'h03
`define ADCC_DIVM1_2      6'h01

// ==================================================================
// conversion time in converter clocks, from the figures at 32 MHz /64
`define ADCC_FCLK_REF_MHZ   32
`define ADCC_DIV_REF        64
`define ADCC_TCONV_STD1_NS  38000
`define ADCC_TCONV_STD2_NS  34000
`define ADCC_CONV_CLKS_STD1 ((`ADCC_TCONV_STD1_NS * `ADCC_FCLK_REF_MHZ) \
                             / (1000 * `ADCC_DIV_REF))
`define ADCC_CONV_CLKS_STD2 ((`ADCC_TCONV_STD2_NS * `ADCC_FCLK_REF_MHZ) \
                             / (1000 * `ADCC_DIV_REF))
`define ADCC_SCAN_LAST      2'h3

`endif

// ==== src/adcc_pkg.sv ====
`default_nettype none

package adcc_pkg;

   typedef enum logic [1:0] {
      ADCC_TRG_SW      = 2'b00,
      ADCC_TRG_SW_ALT  = 2'b01,
      ADCC_TRG_HW_NOW  = 2'b10,
      ADCC_TRG_HW_WAIT = 2'b11
   } adcc_trig_mode_t;

   typedef enum logic [1:0] {
      ADCC_SRC_TIMER1 = 2'b00,
      ADCC_SRC_BAD    = 2'b01,
      ADCC_SRC_RTC    = 2'b10,
      ADCC_SRC_ITV    = 2'b11
   } adcc_trig_src_t;

   typedef enum logic {
      ADCC_IDLE = 1'b0,
      ADCC_CONV = 1'b1
   } adcc_state_t;

   typedef enum logic [0:0] {
      ADCC_EV_CONV_END = 1'b0,
      ADCC_EV_BAD_SET  = 1'b1
   } adcc_event_t;

endpackage

`default_nettype wire

// ==== src/adcc_conv_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface adcc_conv_if;
   logic       start;
   logic       abort;
   logic [2:0] div_code;
   logic       speed2;
   logic       busy;
   logic       done;

   modport ctl (output start, abort, div_code, speed2, input busy, done);
   modport tmr (input start, abort, div_code, speed2, output busy, done);
endinterface

`default_nettype wire

// ==== src/adcc_conv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"

module adcc_conv_timer (
   input wire logic   pclk,     // system clock
   input wire logic   presetn,  // async reset, active low
   adcc_conv_if.tmr   cv        // conversion request and completion
);

   logic [5:0] pre_r;
   logic [4:0] cnt_r;
   logic       busy_r;
   logic       done_r;
   logic [5:0] ratio_m1;
   logic [4:0] clks_m1;
   wire        tick = busy_r && (pre_r == 6'h00);
   wire        last = tick && (cnt_r == 5'h00);

   // ==================================================================
   // divider and conversion length
   always_comb begin
      case (cv.div_code)
         3'h0:    ratio_m1 = `ADCC_DIVM1_64;
         3'h1:    ratio_m1 = `ADCC_DIVM1_32;
         3'h2:    ratio_m1 = `ADCC_DIVM1_16;
         3'h3:    ratio_m1 = `ADCC_DIVM1_8;
         3'h4:    ratio_m1 = `ADCC_DIVM1_6;
         3'h5:    ratio_m1 = `ADCC_DIVM1_5;
         3'h6:    ratio_m1 = `ADCC_DIVM1_4;
         default: ratio_m1 = `ADCC_DIVM1_2;
      endcase
   end

   assign clks_m1 = cv.speed2 ? 5'(`ADCC_CONV_CLKS_STD2 - 1)
                              : 5'(`ADCC_CONV_CLKS_STD1 - 1);

   // ==================================================================
   // speed is sampled at start; a mid-conversion divider change applies at the next tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r  <= 6'h00;
         cnt_r  <= 5'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= last && !cv.abort;
         if (cv.abort) begin
            busy_r <= 1'b0;
         end else if (cv.start) begin
            busy_r <= 1'b1;
            pre_r  <= ratio_m1;
            cnt_r  <= clks_m1;
         end else if (tick) begin
            pre_r  <= ratio_m1;
            cnt_r  <= cnt_r - 5'h01;
            busy_r <= !last;
         end else if (busy_r) begin
            pre_r  <= pre_r - 6'h01;
         end
      end
   end

   assign cv.busy = busy_r;
   assign cv.done = done_r;

endmodule

`default_nettype wire

// ==== src/adcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"

// Operation
// - The clock gate bit stops the converter when 0 and runs it when 1.
// - The scan bit picks one selected channel (0) or a group scan (1).
// - Divider codes 0 to 7 divide the clock by 64,32,16,8,6,5,4,2.
// - Speed code 00 gives a 19-clock and 01 a 17-clock conversion.
// - Trigger mode 0x is software, 10 hardware no-wait, 11 hw wait.
// - The one-shot bit clears start after one conversion (one scan) in software mode, else repeats.
// - Trigger source 00 timer, 10 rtc, 11 interval timer; 01 is bad.
// - Positive reference 00 supply, 01 pin, 10 internal; 11 is bad.
// - The negative reference bit picks ground (0) or the pin (1).
// - The end event fires inside the limits only; the outside-check bit of mode2 is not writable.
// - The wakeup bit enables a wake request from the low power state.
// - The resolution bit gives 10-bit (0) or 8-bit (1) results.
// - Two writable 8-bit registers hold the upper and lower limits.
// - Codes 0-7 pick inputs 0-7 and codes 16-19 pick inputs 16-19.
// - Internal codes 0 and 1 pick the sensor and reference; no other.
module adcc_top (
   input  wire logic        pclk,                     // system clock
   input  wire logic        presetn,                  // async reset, low
   input  wire logic        psel,                     // apb select
   input  wire logic        penable,                  // apb enable
   input  wire logic        pwrite,                   // apb write
   input  wire logic [7:0]  paddr,                    // apb byte address
   input  wire logic [31:0] pwdata,                   // apb write data
   output logic      [31:0] prdata,                   // apb read data
   output logic             pready,                   // apb ready
   output logic             pslverr,                  // apb error
   input  wire logic        timer_ch1_interrupt,      // hw trigger pulse
   input  wire logic        rtc_interrupt,            // hw trigger pulse
   input  wire logic        interval_timer_interrupt, // hw trigger pulse
   input  wire logic [9:0]  conversion_result,        // raw converter code
   input  wire logic        low_power_wake_state,     // chip in low_power_wake_state
   output logic             converter_clock_gate,     // converter clock on
   output logic             comparator_enable,        // comparator powered
   output logic             conv_active,              // conversion running
   output logic [5:0]       channel_select,           // {internal, code}
   output logic [1:0]       pos_reference,            // + reference select
   output logic             neg_reference,            // - reference select
   output logic             resolution_8bit,          // 8-bit result mode
   output logic             conversion_end_interrupt, // end event pulse
   output logic             low_power_wake_state_wakeup,            // wake request pulse
   output logic             irq                       // level interrupt
);

   // ==================================================================
   // registers
   logic [7:0]          clken_r, mode0_r, mode1_r, mode2_r;
   logic [7:0]          upper_r, lower_r, chsel_r;
   logic [9:0]          result_r;
   logic [1:0]          stat_r, mask_r;
   logic [1:0]          scan_r;
   adcc_pkg::adcc_state_t state_r;
   logic [31:0]         prdata_r;
   logic                pready_r, pslverr_r, irq_r, cend_r, wake_r;
   logic                gate_r, cmp_r, act_r;
   logic [5:0]          chan_r;

   adcc_conv_if cv ();

   adcc_conv_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .cv      (cv.tmr)
   );

   // ==================================================================
   // apb decode
   wire setup   = psel && !penable;
   wire access  = psel && penable && pready_r;
   wire hit_ck  = paddr == `ADCC_OFF_CLKEN;
   wire hit_m0  = paddr == `ADCC_OFF_MODE0;
   wire hit_m1  = paddr == `ADCC_OFF_MODE1;
   wire hit_m2  = paddr == `ADCC_OFF_MODE2;
   wire hit_ul  = paddr == `ADCC_OFF_UPPER;
   wire hit_ll  = paddr == `ADCC_OFF_LOWER;
   wire hit_cs  = paddr == `ADCC_OFF_CHSEL;
   wire hit_rs  = paddr == `ADCC_OFF_RESULT;
   wire hit_st  = paddr == `ADCC_OFF_STATUS;
   wire hit_mk  = paddr == `ADCC_OFF_MASK;
   wire hit     = hit_ck | hit_m0 | hit_m1 | hit_m2 | hit_ul | hit_ll |
                  hit_cs | hit_rs | hit_st | hit_mk;
   wire wr      = access && pwrite;
   wire gate    = clken_r[`ADCC_CLKGATE_BIT];
   // converter registers are frozen while its clock is cut
   wire wr_conv = wr && gate;
   wire [7:0] wd = pwdata[7:0];

   wire [31:0] rd_mux =
      hit_ck ? {24'h000000, clken_r} :
      hit_m0 ? {24'h000000, mode0_r} :
      hit_m1 ? {24'h000000, mode1_r} :
      hit_m2 ? {24'h000000, mode2_r} :
      hit_ul ? {24'h000000, upper_r} :
      hit_ll ? {24'h000000, lower_r} :
      hit_cs ? {24'h000000, chsel_r} :
      hit_rs ? {22'h000000, result_r} :
      hit_st ? {30'h00000000, stat_r} :
      hit_mk ? {30'h00000000, mask_r} : 32'h00000000;

   // ==================================================================
   // field decode
   wire       start_bit = mode0_r[`ADCC_START_BIT];
   wire       scan_mode = mode0_r[`ADCC_SCAN_BIT];
   wire       cmp_en    = mode0_r[`ADCC_CMPEN_BIT];
   wire [1:0] trg_mode  = mode1_r[`ADCC_TRG_HI:`ADCC_TRG_LO];
   wire       one_shot  = mode1_r[`ADCC_ONESHOT_BIT];
   wire [1:0] trg_src   = mode1_r[`ADCC_TSRC_HI:`ADCC_TSRC_LO];
   wire       rchk      = mode2_r[`ADCC_RCHK_BIT];
   wire       wake_en   = mode2_r[`ADCC_WAKE_BIT];
   wire       res8      = mode2_r[`ADCC_RES_BIT];
   wire       sw_mode   = !trg_mode[1];
   wire       wait_mode = trg_mode == adcc_pkg::ADCC_TRG_HW_WAIT;
   wire       trg_hit   =
      (trg_src == adcc_pkg::ADCC_SRC_TIMER1) ? timer_ch1_interrupt :
      (trg_src == adcc_pkg::ADCC_SRC_RTC)    ? rtc_interrupt :
      (trg_src == adcc_pkg::ADCC_SRC_ITV)    ? interval_timer_interrupt :
                                               1'b0;

   // a bad code is still stored; the flag tells software it erred
   wire [4:0] wcode   = wd[`ADCC_CODE_HI:`ADCC_CODE_LO];
   wire       ch_ok   = wd[`ADCC_ISS_BIT] ? (wcode[4:1] == 4'h0)
                      : (wcode[4:3] == 2'h0) ||
                        (wcode[4:2] == 3'h4);
   wire       bad_set = wr_conv &&
      ((hit_m1 && wd[`ADCC_TSRC_HI:`ADCC_TSRC_LO] ==
                  adcc_pkg::ADCC_SRC_BAD) ||
       (hit_m2 && wd[`ADCC_PREF_HI:`ADCC_PREF_LO] == 2'h3) ||
       (hit_cs && !ch_ok));

   // ==================================================================
   // conversion control
   wire idle     = state_r == adcc_pkg::ADCC_IDLE;
   wire converting = state_r == adcc_pkg::ADCC_CONV;
   // wait mode powers the comparator itself, so its enable is not needed
   wire go       = idle && !cv.busy && gate && start_bit &&
                   (sw_mode ? cmp_en
                            : trg_hit && (cmp_en || wait_mode));
   wire abort    = converting && (!gate || !start_bit);
   // an abort in the done cycle drops both the result and the event
   wire done     = converting && cv.done && !abort;
   wire scan_end = !scan_mode || (scan_r == `ADCC_SCAN_LAST);
   wire hw_clr   = done && one_shot && sw_mode && scan_end;
   wire sw_set   = wr_conv && hit_m0 && wd[`ADCC_START_BIT];

   wire [7:0] res_hi = conversion_result[9:2];
   wire in_rng  = (res_hi >= lower_r) && (res_hi <= upper_r);
   wire pass    = rchk ? !in_rng : in_rng;
   wire [9:0] res_nxt = res8 ? {res_hi, 2'b00}
                             : conversion_result;

   wire [1:0] ev      = {bad_set, done && pass};
   wire [1:0] w1c     = (wr && hit_st) ? pwdata[1:0] : 2'b00;
   // a new event wins over a clear in the same cycle
   wire [1:0] stat_nxt = (stat_r & ~w1c) | ev;
   wire [4:0] scan_code = chsel_r[4:0] + {3'h0, scan_r};
   wire [5:0] chan_nxt  = {chsel_r[`ADCC_ISS_BIT],
                           scan_mode ? scan_code : chsel_r[4:0]};

   wire [7:0] mode0_wr  = (wr_conv && hit_m0) ? wd : mode0_r;
   wire       start_nxt = sw_set || (mode0_wr[`ADCC_START_BIT] && !hw_clr);

   assign cv.start    = go;
   assign cv.abort    = abort;
   assign cv.div_code = mode0_r[`ADCC_DIV_HI:`ADCC_DIV_LO];
   assign cv.speed2   = mode0_r[`ADCC_SPD_LO];

   // ==================================================================
   // apb slave, answers in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && !hit;
         prdata_r  <= setup ? rd_mux : prdata_r;
      end
   end

   // ==================================================================
   // register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clken_r <= `ADCC_RST_CLKEN;
         mode0_r <= `ADCC_RST_MODE0;
         mode1_r <= `ADCC_RST_MODE1;
         mode2_r <= `ADCC_RST_MODE2;
         upper_r <= `ADCC_RST_UPPER;
         lower_r <= `ADCC_RST_LOWER;
         chsel_r <= `ADCC_RST_CHSEL;
         stat_r  <= 2'h0;
         mask_r  <= 2'h0;
      end else begin
         if (wr && hit_ck)
            clken_r <= wd & `ADCC_WMASK_CLKEN;
         mode0_r <= {start_nxt, mode0_wr[6:0]};
         if (wr_conv && hit_m1)
            mode1_r <= wd & `ADCC_WMASK_MODE1;
         if (wr_conv && hit_m2)
            mode2_r <= wd & `ADCC_WMASK_MODE2;
         if (wr_conv && hit_ul)
            upper_r <= wd;
         if (wr_conv && hit_ll)
            lower_r <= wd;
         if (wr_conv && hit_cs)
            chsel_r <= wd & `ADCC_WMASK_CHSEL;
         stat_r <= stat_nxt;
         if (wr && hit_mk)
            mask_r <= pwdata[1:0];
      end
   end

   // ==================================================================
   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r  <= adcc_pkg::ADCC_IDLE;
         scan_r   <= 2'h0;
         result_r <= 10'h000;
      end else begin
         case (state_r)
            adcc_pkg::ADCC_IDLE: begin
               if (!start_bit)
                  scan_r <= 2'h0;
               if (go)
                  state_r <= adcc_pkg::ADCC_CONV;
            end
            adcc_pkg::ADCC_CONV: begin
               if (abort) begin
                  state_r <= adcc_pkg::ADCC_IDLE;
                  scan_r  <= 2'h0;
               end else if (done) begin
                  state_r  <= adcc_pkg::ADCC_IDLE;
                  result_r <= res_nxt;
                  scan_r   <= scan_end ? 2'h0 : scan_r + 2'h1;
               end
            end
            default: state_r <= adcc_pkg::ADCC_IDLE;
         endcase
      end
   end

   // ==================================================================
   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r <= 1'b0;
         cmp_r  <= 1'b0;
         act_r  <= 1'b0;
         chan_r <= 6'h00;
         cend_r <= 1'b0;
         wake_r <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         gate_r <= gate;
         cmp_r  <= gate && (cmp_en || (wait_mode && converting));
         act_r  <= (go || converting) && !abort && !done;
         chan_r <= chan_nxt;
         cend_r <= done && pass;
         wake_r <= done && pass && wake_en &&
                   low_power_wake_state;
         irq_r  <= |(stat_nxt & mask_r);
      end
   end

   assign prdata                   = prdata_r;
   assign pready                   = pready_r;
   assign pslverr                  = pslverr_r;
   assign converter_clock_gate     = gate_r;
   assign comparator_enable        = cmp_r;
   assign conv_active              = act_r;
   assign channel_select           = chan_r;
   assign pos_reference            = mode2_r[`ADCC_PREF_HI:`ADCC_PREF_LO];
   assign neg_reference            = mode2_r[`ADCC_NREF_BIT];
   assign resolution_8bit          = res8;
   assign conversion_end_interrupt = cend_r;
   assign low_power_wake_state_wakeup            = wake_r;
   assign irq                      = irq_r;

   // ==================================================================
   // checks
   sequence s_done_in;
      done && pass;
   endsequence

   property p_gate_stop;
      @(posedge pclk) disable iff (!presetn)
      !gate |=> !conv_active;
   endproperty
   a_gate_stop: assert property (p_gate_stop)
      else $error("conversion active with clock cut");

   property p_div2_std1;
      @(posedge pclk) disable iff (!presetn || abort)
      cv.start && cv.div_code == 3'h7 && !cv.speed2 && gate
      |-> ##39 cv.done;
   endproperty
   a_div2_std1: assert property (p_div2_std1)
      else $error("divide-by-2 standard 1 length wrong");

   property p_div4_std2;
      @(posedge pclk) disable iff (!presetn || abort)
      cv.start && cv.div_code == 3'h6 && cv.speed2 && gate && start_bit
      ##1 (!abort)[*8] |-> ##61 cv.done;
   endproperty
   a_div4_std2: assert property (p_div4_std2)
      else $error("divide-by-4 standard 2 length wrong");

   property p_sw_start;
      @(posedge pclk) disable iff (!presetn)
      idle && !cv.busy && gate && start_bit && cmp_en && sw_mode
      |=> conv_active;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software start not taken");

   property p_hw_no_trig;
      @(posedge pclk) disable iff (!presetn)
      idle && !sw_mode && !trg_hit |=> idle;
   endproperty
   a_hw_no_trig: assert property (p_hw_no_trig)
      else $error("hardware mode started without trigger");

   property p_end_event;
      @(posedge pclk) disable iff (!presetn)
      s_done_in |=> conversion_end_interrupt && stat_r[0];
   endproperty
   a_end_event: assert property (p_end_event)
      else $error("end event missing for passing result");

   property p_oneshot;
      @(posedge pclk) disable iff (!presetn)
      done && one_shot && sw_mode && !scan_mode && !sw_set |=> !start_bit;
   endproperty
   a_oneshot: assert property (p_oneshot)
      else $error("one-shot did not clear start");

   property p_res8;
      @(posedge pclk) disable iff (!presetn)
      done && res8 |=> result_r[1:0] == 2'b00;
   endproperty
   a_res8: assert property (p_res8)
      else $error("8-bit result has low bits set");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      low_power_wake_state_wakeup |-> $past(wake_en) && $past(low_power_wake_state);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake request while disabled");

endmodule

`default_nettype wire

// ==== tb/adcc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
   input  wire logic       pclk,   // system clock
   input  wire logic       active, // conversion running
   input  wire logic [9:0] level,  // level on the chosen input
   output logic      [9:0] code    // raw code into the block
);
   initial code = 10'h000;
   // between conversions the code toggles, so a stale sample is caught
   always @(posedge pclk) begin
      code <= active ? level : ~code;
   end
endmodule
`default_nettype wire

// ==== tb/adcc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"
module adcc_top_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, eoc, irq;
   logic [9:0] code, level = 10'h2a5;
   logic act, gck, cmpe, nref, r8, wake, lpw = 0, itv = 0;
   logic [1:0] pref;
   logic [5:0] chan;
   int mismatches = 0, n_compared = 0;
   typedef struct { logic [7:0] a; logic [31:0] d, e; } adcc_row_t;
   adcc_row_t rows [5] = '{'{`ADCC_OFF_MODE1, 32'he3, 32'he3},
      '{`ADCC_OFF_MODE2, 32'ha7, 32'ha5}, '{`ADCC_OFF_UPPER, 32'h5a, 32'h5a},
      '{`ADCC_OFF_LOWER, 32'h12, 32'h12}, '{`ADCC_OFF_CHSEL, 32'h61, 32'h01}};
   always #12.5 pclk = ~pclk;
   adcc_analog_model i_model (.pclk(pclk), .active(act), .level(level),
      .code(code));
   adcc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_ch1_interrupt(1'b0), .rtc_interrupt(1'b0),
      .interval_timer_interrupt(itv), .conversion_result(code),
      .low_power_wake_state(lpw), .converter_clock_gate(gck),
      .comparator_enable(cmpe), .conv_active(act), .channel_select(chan),
      .pos_reference(pref), .neg_reference(nref), .resolution_8bit(r8),
      .conversion_end_interrupt(eoc), .low_power_wake_state_wakeup(wake), .irq(irq));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (i >= 20) begin
         mismatches++;
         results();
      end
   endtask
   // returns on the falling edge after the conversion ends, while the
   // one-cycle end outputs still stand
   task automatic convert(input logic [7:0] lower, input logic [7:0] m0,
                          input logic trig);
      int i;
      logic seen;
      seen = 1'b0;
      apb(1, `ADCC_OFF_LOWER, {24'h0, lower});
      apb(1, `ADCC_OFF_MODE0, {24'h0, m0});
      itv <= trig;
      @(posedge pclk);
      itv <= 1'b0;
      for (i = 0; i < 200 && !(seen && act === 1'b0); i++) begin
         @(negedge pclk);
         seen = seen | (act === 1'b1);
      end
      if (i >= 200) begin
         mismatches++;
         results();
      end
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `ADCC_OFF_UPPER, 0);
      chk(rd, 32'hff);
      apb(1, `ADCC_OFF_UPPER, 32'h33);
      apb(0, `ADCC_OFF_UPPER, 0);
      chk(rd, 32'hff);
      apb(0, 8'h40, 0);
      chk({31'h0, err}, 32'h1);
      apb(1, `ADCC_OFF_CLKEN, 32'h20);
      foreach (rows[k]) begin
         apb(1, rows[k].a, rows[k].d);
         apb(0, rows[k].a, 0);
         chk(rd, rows[k].e);
      end
      chk({21'h0, gck, pref, nref, r8, chan}, 32'h6c1);
      apb(1, `ADCC_OFF_UPPER, 32'hff);
      apb(1, `ADCC_OFF_MODE2, 32'h0);
      apb(1, `ADCC_OFF_MODE1, 32'h20);
      apb(1, `ADCC_OFF_MASK, 32'h1);
      // result code 0x2a5 ranks as 0xa9, below this lower limit
      convert(8'hc0, 8'hb9, 1'b0);
      chk({31'h0, eoc}, 32'h0);
      @(posedge pclk);
      apb(0, `ADCC_OFF_STATUS, 0);
      chk(rd, 32'h0);
      // 8-bit results and wakeup with the chip asleep, divide by 4
      apb(1, `ADCC_OFF_MODE2, 32'h05);
      lpw <= 1'b1;
      convert(8'h00, 8'hb3, 1'b0);
      chk({27'h0, eoc, wake, cmpe, act, irq}, 32'h1d);
      @(posedge pclk);
      apb(0, `ADCC_OFF_RESULT, 0);
      chk(rd, 32'h2a4);
      apb(1, `ADCC_OFF_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      // internal source with code 2 is a prohibited selector
      apb(1, `ADCC_OFF_CHSEL, 32'h82);
      apb(0, `ADCC_OFF_STATUS, 0);
      chk(rd, 32'h2);
      // hardware trigger without wait, from the interval timer
      apb(1, `ADCC_OFF_MODE1, 32'ha3);
      convert(8'h00, 8'hb9, 1'b1);
      chk({31'h0, eoc}, 32'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `ADCC_OFF_CLKEN, 0);
      chk({rd[30:0], irq}, 32'h0);
      results();
   end
endmodule
`default_nettype wire
